// ### hdl/vandiag_top.sv
// Overview of operation
// RULE_01: three receive inputs: differential and two single-wire receivers.
// RULE_02: one-wire failure enters degraded mode, routing the healthy single wire.
// RULE_03: failing wire working again returns to nominal, differential reconnected.
// RULE_04: both wires failed gives the major error state.
// RULE_05: fault_state_hi/lo always report state: 00 nominal, 01/10 degraded, 11 major.
// RULE_06: in major error alternate single wires once per diagnosis period.
// RULE_07: mismatch flag set when any one input differs from the others.
// RULE_08: mismatch flag cleared only by idle return pulse or reset.
// RULE_09: inputs filtered, transition accepted after five equal sixteenth-slot samples.
// RULE_10: four edges on one single wire, none on other: silent one faulty.
// RULE_11: fewer than four edges on selected input per period: major error.
// RULE_12: while transmitting dominant, wire seen recessive is faulty, dominant one good.
// RULE_13: eight consecutive dominant timeslots: major error.
// RULE_14: frame failure or no transitions between two ticks are failure causes.
// RULE_15: idle return pulse at end of frame returns forced modes to nominal.
// RULE_16: automatic mode returns to nominal after two fault-free period ticks.
// RULE_17: period tick from timeslot divider or manual command.
// RULE_18: tx window asserted at transmission start for each access kind.
// RULE_19: tx window dropped after end of frame, lost arbitration or violation.
// RULE_20: no tx window for acknowledge-only; tx diagnosis only when enabled.
// RULE_21: two-bit select: 00 diff, 01 wire b, 10 wire a, 11 automatic.
// RULE_22: divider divides timeslot clock by 64 times two to a four-bit code.
// RULE_23: software holds the manual tick at least two timeslot clocks.
// RULE_24: pulsed coding receives on differential only, diagnosis inactive.
// RULE_25: edge window restarts on each tick; reset returns to clean nominal.
//
// The address-and-strobe port and the register offsets were left to the implementer.
`include "vandiag_defines.svh"
`default_nettype none
module vandiag_top #(
    parameter int DIV_CODE_W = 4
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic slot_tick,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic diff_rx_in,
    input wire logic single_wire_rx_a,
    input wire logic single_wire_rx_b,
    input wire logic line_tx_out,
    input wire logic tx_start,
    input wire logic tx_ack_only,
    input wire logic tx_stop,
    input wire logic end_of_frame,
    output logic rx_data_out,
    output logic fault_state_hi,
    output logic fault_state_lo,
    output logic input_mismatch_flag,
    output logic idle_return_pulse,
    output logic diag_period_tick,
    output logic tx_active_window
);
    import vandiag_pkg::*;

    logic [7:0] ctrl_q;
    logic pulsed_q;
    vandiag_state_t state_q;
    logic [3:0] sub_q;
    logic samp;
    logic [2:0] raw;
    logic [2:0] filt_q;
    logic [2:0] filt_prev_q;
    logic [2:0] edge_v;
    logic [2:0] cnt_q [3];
    logic [21:0] div_q;
    logic [1:0] man_q;
    logic tick_req;
    logic [2:0] ecnt_a_q;
    logic [2:0] ecnt_b_q;
    logic [2:0] ecnt_sel_q;
    logic [3:0] dom_q;
    logic [1:0] tx_dly_q;
    logic [1:0] clean_q;
    logic alt_q;
    logic frame_fail_q;
    logic fault_seen_q;
    vandiag_sel_t sel_mode;
    logic sel_in;
    logic automatic_mode;
    logic diag_on;

    assign sel_mode = {ctrl_q[`VD_CTRL_MODE_HI], ctrl_q[`VD_CTRL_MODE_LO]};
    assign automatic_mode = (sel_mode == 2'b11);
    assign diag_on = !pulsed_q; // RULE_24
    assign samp = slot_tick || (sub_q == `VD_SUBSLOT);
    assign raw = {single_wire_rx_b, single_wire_rx_a, diff_rx_in}; // RULE_01

    function automatic logic [21:0] div_limit(input logic [3:0] code);
        div_limit = `VD_DIV_BASE << code; // RULE_22
    endfunction : div_limit

    // register port: writes and one-cycle-late read data
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= `VD_CTRL_RESET;
            pulsed_q <= 1'b0;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == `VD_ADDR_CTRL) begin
                ctrl_q <= reg_wdata;
            end
            if (reg_addr == `VD_ADDR_STATUS) begin
                pulsed_q <= reg_wdata[`VD_CTRL_PULSED];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= 8'h00;
            if (reg_rd && reg_addr == `VD_ADDR_CTRL) begin
                reg_rdata <= ctrl_q;
            end else if (reg_rd && reg_addr == `VD_ADDR_STATUS) begin
                reg_rdata <= {pulsed_q, 4'h0, input_mismatch_flag,
                              fault_state_hi, fault_state_lo};
            end
        end
    end

    // sixteenth-of-timeslot sampling strobe, realigned on each slot
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sub_q <= 4'h0;
        end else if (clk_en) begin
            sub_q <= slot_tick ? 4'h0 : sub_q + 4'h1;
        end
    end

    // per-input glitch filter
    for (genvar i = 0; i < 3; i++) begin : g_filt
        always_ff @(posedge clk or negedge reset_n) begin
            if (!reset_n) begin
                filt_q[i] <= 1'b1;
                cnt_q[i] <= 3'h0;
            end else if (clk_en && samp) begin
                if (raw[i] == filt_q[i]) begin
                    cnt_q[i] <= 3'h0;
                end else if (cnt_q[i] == `VD_FILT_SAMPLES - 3'h1) begin
                    filt_q[i] <= raw[i]; // RULE_09
                    cnt_q[i] <= 3'h0;
                end else begin
                    cnt_q[i] <= cnt_q[i] + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            filt_prev_q <= 3'b111;
        end else if (clk_en) begin
            filt_prev_q <= filt_q;
        end
    end
    assign edge_v = filt_q ^ filt_prev_q;

    // diagnosis period tick: divider or manual command
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= 22'h0;
            man_q <= 2'b00;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == `VD_ADDR_CMD) begin
                man_q <= {man_q[0], reg_wdata[`VD_CMD_MANUAL]};
            end else begin
                man_q <= {man_q[0], 1'b0};
            end
            if (!ctrl_q[`VD_CTRL_DIVEN]) begin
                div_q <= 22'h0;
            end else if (slot_tick) begin
                div_q <= (div_q >= div_limit(ctrl_q[7:4]) - 22'h1) ? 22'h0 : div_q + 22'h1;
            end
        end
    end
    assign tick_req = (ctrl_q[`VD_CTRL_DIVEN] && slot_tick && div_q == 22'h0)
                      || (man_q == 2'b01); // RULE_17

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            diag_period_tick <= 1'b0;
        end else if (clk_en) begin
            diag_period_tick <= tick_req;
        end
    end

    // idle return pulse: only outside automatic mode
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            idle_return_pulse <= 1'b0;
        end else if (clk_en) begin
            idle_return_pulse <= end_of_frame && !automatic_mode; // RULE_15
        end
    end

    // transmission window
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_active_window <= 1'b0;
        end else if (clk_en) begin
            if (!ctrl_q[`VD_CTRL_TIPEN] || tx_stop || end_of_frame) begin
                tx_active_window <= 1'b0; // RULE_19
            end else if (tx_start && !tx_ack_only) begin
                tx_active_window <= 1'b1; // RULE_18 RULE_20
            end
        end
    end

    // mismatch flag: set wins over clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            input_mismatch_flag <= 1'b0;
        end else if (clk_en) begin
            if (diag_on && !(filt_q == 3'b000 || filt_q == 3'b111)) begin
                input_mismatch_flag <= 1'b1; // RULE_07
            end else if (idle_return_pulse) begin
                input_mismatch_flag <= 1'b0; // RULE_08
            end
        end
    end

    // edge counters per diagnosis period
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ecnt_a_q <= 3'h0;
            ecnt_b_q <= 3'h0;
            ecnt_sel_q <= 3'h0;
        end else if (clk_en) begin
            // the idle return restarts the window too, or stale counts re-degrade at once
            if (diag_period_tick || idle_return_pulse) begin
                ecnt_a_q <= 3'h0; // RULE_25
                ecnt_b_q <= 3'h0;
                ecnt_sel_q <= 3'h0;
            end else begin
                if (edge_v[1] && ecnt_a_q != `VD_EDGE_LIMIT) ecnt_a_q <= ecnt_a_q + 3'h1;
                if (edge_v[2] && ecnt_b_q != `VD_EDGE_LIMIT) ecnt_b_q <= ecnt_b_q + 3'h1;
                if ((rx_data_out != sel_in) && ecnt_sel_q != `VD_EDGE_LIMIT) begin
                    ecnt_sel_q <= ecnt_sel_q + 3'h1; // RULE_11
                end
            end
        end
    end

    // consecutive dominant timeslots on the selected input
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dom_q <= 4'h0;
        end else if (clk_en && slot_tick) begin
            if (sel_in) begin
                dom_q <= 4'h0;
            end else if (dom_q != `VD_DOM_LIMIT) begin
                dom_q <= dom_q + 4'h1; // RULE_13
            end
        end
    end

    // transmit data delayed to line up with the filters
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_dly_q <= 2'b11;
        end else if (clk_en && slot_tick) begin
            tx_dly_q <= {tx_dly_q[0], line_tx_out};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_fail_q <= 1'b0;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == `VD_ADDR_CMD && reg_wdata[`VD_CMD_FRAME_FAIL]) begin
                frame_fail_q <= 1'b1; // RULE_14
            end else if (diag_period_tick) begin
                frame_fail_q <= 1'b0;
            end
        end
    end

    // diagnosis state machine
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= VD_NOMINAL; // RULE_25
            clean_q <= 2'b00;
            fault_seen_q <= 1'b0;
        end else if (clk_en) begin
            if (!diag_on) begin
                state_q <= VD_NOMINAL;
            end else if (dom_q == `VD_DOM_LIMIT || frame_fail_q) begin
                state_q <= VD_MAJOR; // RULE_13 RULE_14
                fault_seen_q <= 1'b1;
            end else if (idle_return_pulse) begin
                state_q <= VD_NOMINAL; // RULE_15 RULE_03
            end else if (diag_period_tick) begin
                // tick first: a stale edge count at the tick only restarts the window
                fault_seen_q <= 1'b0;
                if (ecnt_sel_q < `VD_EDGE_LIMIT) begin
                    state_q <= VD_MAJOR; // RULE_11 RULE_14
                    clean_q <= 2'b00;
                end else if (automatic_mode) begin
                    clean_q <= {clean_q[0], !fault_seen_q};
                    if (clean_q[0] && !fault_seen_q) begin
                        state_q <= VD_NOMINAL; // RULE_16 RULE_03
                    end
                end
            end else if (tx_active_window && tx_dly_q != 2'b11 && filt_q[1] != filt_q[2]) begin
                // a recessive wire under our own dominant drive is the faulty one
                state_q <= filt_q[1] ? VD_DEG_A : VD_DEG_B; // RULE_12
                fault_seen_q <= 1'b1;
            end else if (ecnt_b_q == `VD_EDGE_LIMIT && ecnt_a_q == 3'h0) begin
                state_q <= (state_q == VD_DEG_B) ? VD_MAJOR : VD_DEG_A; // RULE_02 RULE_10
                fault_seen_q <= 1'b1;
            end else if (ecnt_a_q == `VD_EDGE_LIMIT && ecnt_b_q == 3'h0) begin
                state_q <= (state_q == VD_DEG_A) ? VD_MAJOR : VD_DEG_B; // RULE_04 RULE_10
                fault_seen_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            alt_q <= 1'b0;
        end else if (clk_en && diag_period_tick && state_q == VD_MAJOR) begin
            alt_q <= !alt_q; // RULE_06
        end
    end

    // input selection
    always_comb begin
        sel_in = diff_rx_in;
        if (pulsed_q) begin
            sel_in = filt_q[0]; // RULE_24
        end else begin
            case (sel_mode) // RULE_21
                2'b00: sel_in = filt_q[0];
                2'b01: sel_in = filt_q[2];
                2'b10: sel_in = filt_q[1];
                default: begin
                    case (state_q)
                        VD_NOMINAL: sel_in = filt_q[0];
                        VD_DEG_A: sel_in = filt_q[2]; // RULE_02
                        VD_DEG_B: sel_in = filt_q[1];
                        VD_MAJOR: sel_in = alt_q ? filt_q[2] : filt_q[1]; // RULE_06
                        default: sel_in = filt_q[0];
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_data_out <= 1'b1;
            fault_state_hi <= 1'b0;
            fault_state_lo <= 1'b0;
        end else if (clk_en) begin
            rx_data_out <= sel_in;
            fault_state_hi <= (state_q == VD_DEG_B) || (state_q == VD_MAJOR); // RULE_05
            fault_state_lo <= (state_q == VD_DEG_A) || (state_q == VD_MAJOR); // RULE_05
        end
    end

    property p_mismatch_set;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && diag_on && filt_q == 3'b001) |=> input_mismatch_flag;
    endproperty
    a_mismatch_set: assert property (p_mismatch_set) else $error("mismatch not flagged"); // RULE_07

    property p_mismatch_hold;
        @(posedge clk) disable iff (!reset_n)
        (input_mismatch_flag && !idle_return_pulse) |=> input_mismatch_flag;
    endproperty
    a_mismatch_hold: assert property (p_mismatch_hold) else $error("flag lost"); // RULE_08

    property p_major_code;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && state_q == VD_MAJOR) |=> (fault_state_hi && fault_state_lo);
    endproperty
    a_major_code: assert property (p_major_code) else $error("major code wrong"); // RULE_05

    property p_dom_major;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && diag_on && dom_q == `VD_DOM_LIMIT) |=> state_q == VD_MAJOR;
    endproperty
    a_dom_major: assert property (p_dom_major) else $error("no major on dominant"); // RULE_13

    property p_ri_auto;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && automatic_mode) |=> !idle_return_pulse;
    endproperty
    a_ri_auto: assert property (p_ri_auto) else $error("pulse in auto mode"); // RULE_15

    property p_ack_only;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && !tx_active_window && tx_ack_only) |=> !tx_active_window;
    endproperty
    a_ack_only: assert property (p_ack_only) else $error("window on ack"); // RULE_20

    property p_stop;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && tx_stop) |=> !tx_active_window;
    endproperty
    a_stop: assert property (p_stop) else $error("window not dropped"); // RULE_19

    property p_pulsed;
        @(posedge clk) disable iff (!reset_n)
        (clk_en && pulsed_q) |=> (state_q == VD_NOMINAL);
    endproperty
    a_pulsed: assert property (p_pulsed) else $error("diagnosis active in pulsed"); // RULE_24

endmodule : vandiag_top
`default_nettype wire

// ### hdl/vandiag_defines.svh
`ifndef VANDIAG_DEFINES_SVH
`define VANDIAG_DEFINES_SVH

// register offsets (byte addresses of the plain register port)
`define VD_ADDR_CTRL 4'h0
`define VD_ADDR_STATUS 4'h4
`define VD_ADDR_CMD 4'h8
// control register fields
`define VD_CTRL_DIV_LSB 4
`define VD_CTRL_MODE_HI 3
`define VD_CTRL_MODE_LO 2
`define VD_CTRL_TIPEN 1
`define VD_CTRL_DIVEN 0
`define VD_CTRL_RESET 8'h00
// control register 2 fields (mode inputs that the table does not hold)
`define VD_CTRL_PULSED 7
// command register fields
`define VD_CMD_MANUAL 0
`define VD_CMD_FRAME_FAIL 1
// status register fields
`define VD_STAT_MISMATCH 2
`define VD_STAT_HI 1
`define VD_STAT_LO 0
// timing counts
`define VD_FILT_SAMPLES 3'h5
`define VD_SUBSLOT 4'hf
`define VD_EDGE_LIMIT 3'h4
`define VD_DOM_LIMIT 4'h8
`define VD_DIV_BASE 22'h000040
`define VD_FILT_DELAY 2'h2

`endif

// ### hdl/vandiag_pkg.sv
`default_nettype none
package vandiag_pkg;
    typedef enum logic [3:0] {
        VD_NOMINAL = 4'b0001,
        VD_DEG_A = 4'b0010,
        VD_DEG_B = 4'b0100,
        VD_MAJOR = 4'b1000
    } vandiag_state_t;
    typedef logic [1:0] vandiag_sel_t;
endpackage : vandiag_pkg
`default_nettype wire

// ### testbench/vandiag_line_model.sv
`default_nettype none
module vandiag_line_model (
    input wire logic bus_lvl,
    input wire logic stuck_a,
    input wire logic stuck_b,
    output logic diff_rx,
    output logic rx_a,
    output logic rx_b
);
    timeunit 1ns;
    timeprecision 1ns;
    // an open wire floats recessive through the receiver bias, so a stuck wire reads 1
    assign diff_rx = bus_lvl;
    assign rx_a = stuck_a | bus_lvl;
    assign rx_b = stuck_b | bus_lvl;
endmodule : vandiag_line_model
`default_nettype wire

// ### testbench/vandiag_top_tb.sv
`include "vandiag_defines.svh"
`default_nettype none
module vandiag_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // sixteen filter samples of 16 clocks each per slot
    localparam int SLOT = 256;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic slot_tick = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic line_tx_out = 1'b1;
    logic tx_start = 1'b0;
    logic tx_ack_only = 1'b0;
    logic tx_stop = 1'b0;
    logic end_of_frame = 1'b0;
    logic bus_lvl = 1'b1;
    logic stuck_a = 1'b0;
    logic stuck_b = 1'b0;
    logic diff_rx_in, single_wire_rx_a, single_wire_rx_b, rx_data_out;
    logic fault_state_hi, fault_state_lo, input_mismatch_flag;
    logic idle_return_pulse, diag_period_tick, tx_active_window;
    logic [7:0] reg_rdata;
    logic [7:0] rv;
    logic [1:0] code, ca, cb;
    logic ri_seen = 1'b0;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    int sdiv = 0;
    int n_tick = 0;
    int last_tick = 0;
    assign code = {fault_state_hi, fault_state_lo};

    vandiag_line_model i_line (.bus_lvl(bus_lvl), .stuck_a(stuck_a), .stuck_b(stuck_b),
        .diff_rx(diff_rx_in), .rx_a(single_wire_rx_a), .rx_b(single_wire_rx_b));
    vandiag_top i_dut (.clk(clk), .reset_n(reset_n), .clk_en(1'b1), .slot_tick(slot_tick),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .diff_rx_in(diff_rx_in), .single_wire_rx_a(single_wire_rx_a),
        .single_wire_rx_b(single_wire_rx_b), .line_tx_out(line_tx_out), .tx_start(tx_start),
        .tx_ack_only(tx_ack_only), .tx_stop(tx_stop), .end_of_frame(end_of_frame),
        .rx_data_out(rx_data_out), .fault_state_hi(fault_state_hi),
        .fault_state_lo(fault_state_lo), .input_mismatch_flag(input_mismatch_flag),
        .idle_return_pulse(idle_return_pulse), .diag_period_tick(diag_period_tick),
        .tx_active_window(tx_active_window));

    always #50 clk = ~clk;
    always @(posedge clk) begin
        sdiv <= (sdiv == SLOT - 1) ? 0 : sdiv + 1;
        slot_tick <= (sdiv == SLOT - 1);
        cyc <= cyc + 1;
        if (idle_return_pulse === 1'b1) ri_seen <= 1'b1;
        if (diag_period_tick === 1'b1) begin
            n_tick <= n_tick + 1;
            last_tick <= cyc;
        end
        // whole run needs about 65000 cycles
        if (cyc == 90000) begin
            n_mismatch++;
            report_and_stop;
        end
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic cyc_wait(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc_wait
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask : rd
    task automatic lvl(input logic v, input int n);
        @(posedge clk);
        bus_lvl <= v;
        cyc_wait(n * SLOT);
    endtask : lvl
    task automatic toggle(input int n);
        for (int i = 0; i < n; i++) lvl(~bus_lvl, 1);
    endtask : toggle
    task automatic mtick;
        wr(`VD_ADDR_CMD, 8'h01);
        cyc_wait(6);
    endtask : mtick
    task automatic strobe(input logic [3:0] k);
        @(posedge clk);
        {tx_start, tx_ack_only, tx_stop, end_of_frame} <= k;
        @(posedge clk);
        {tx_start, tx_ack_only, tx_stop, end_of_frame} <= 4'h0;
        cyc_wait(2);
        #1;
    endtask : strobe
    task automatic wait_tick;
        int k;
        k = n_tick;
        for (int j = 0; j < 40000 && n_tick == k; j++) begin
            @(posedge clk);
            #1;
        end
    endtask : wait_tick
    task automatic do_reset;
        @(posedge clk);
        reset_n <= 1'b0;
        bus_lvl <= 1'b1;
        stuck_a <= 1'b0;
        stuck_b <= 1'b0;
        line_tx_out <= 1'b1;
        cyc_wait(16);
        reset_n <= 1'b1;
        cyc_wait(2);
    endtask : do_reset

    task automatic t_reset;
        chk("state", code, 2'b00);
        chk("rx", rx_data_out, 1'b1);
        chk("mismatch", input_mismatch_flag, 1'b0);
        chk("window", tx_active_window, 1'b0);
        rd(`VD_ADDR_CTRL);
        chk("ctrl", rv, `VD_CTRL_RESET);
        wr(`VD_ADDR_CTRL, 8'ha4);
        rd(`VD_ADDR_CTRL);
        chk("ctrl rw", rv, 8'ha4);
        rd(4'hc);
        chk("unmapped", rv, 8'h00);
        rd(`VD_ADDR_STATUS);
        chk("status", rv, 8'h00);
        wr(`VD_ADDR_CTRL, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_forced;
        stuck_a <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(`VD_ADDR_CTRL, {4'h0, 2'(i), 2'b00});
            lvl(1'b0, 1);
            chk("forced rx", rx_data_out, (i == 2) ? 1'b1 : 1'b0);
            lvl(1'b1, 1);
        end
        chk("mismatch set", input_mismatch_flag, 1'b1);
        lvl(1'b1, 2);
        chk("mismatch held", input_mismatch_flag, 1'b1);
        ri_seen = 1'b0;
        strobe(4'h1);
        chk("idle pulse", ri_seen, 1'b1);
        chk("mismatch clr", input_mismatch_flag, 1'b0);
        chk("state clr", code, 2'b00);
        $display("test forced done");
    endtask : t_forced

    task automatic t_auto(input logic fa, output logic [1:0] c);
        do_reset;
        wr(`VD_ADDR_CTRL, 8'h0c);
        stuck_a <= fa;
        stuck_b <= ~fa;
        toggle(6);
        c = code;
        chk("degraded", ^c, 1'b1);
        lvl(1'b0, 1);
        chk("healthy wire", rx_data_out, 1'b0);
        lvl(1'b1, 1);
        stuck_a <= 1'b0;
        stuck_b <= 1'b0;
        // first tick only restarts the edge window that still holds the fault
        mtick;
        for (int i = 0; i < 2; i++) begin
            toggle(4);
            mtick;
        end
        chk("recovered", code, 2'b00);
        $display("test automatic done");
    endtask : t_auto

    task automatic t_major;
        logic r1;
        do_reset;
        wr(`VD_ADDR_CTRL, 8'h0c);
        mtick;
        mtick;
        chk("silent period", code, 2'b11);
        rd(`VD_ADDR_STATUS);
        chk("status major", rv, 8'h03);
        stuck_a <= 1'b1;
        lvl(1'b0, 1);
        r1 = rx_data_out;
        mtick;
        chk("alternate", r1 ^ rx_data_out, 1'b1);
        do_reset;
        wr(`VD_ADDR_CTRL, 8'h0c);
        lvl(1'b0, 6);
        chk("short dominant", code, 2'b00);
        lvl(1'b0, 4);
        chk("long dominant", code, 2'b11);
        $display("test major done");
    endtask : t_major

    task automatic t_tx;
        do_reset;
        wr(`VD_ADDR_CTRL, 8'h0e);
        strobe(4'h8);
        chk("window on", tx_active_window, 1'b1);
        stuck_a <= 1'b1;
        line_tx_out <= 1'b0;
        lvl(1'b0, 1);
        line_tx_out <= 1'b1;
        lvl(1'b1, 1);
        chk("tx diag", code, ca);
        strobe(4'h2);
        chk("window stop", tx_active_window, 1'b0);
        strobe(4'h8);
        ri_seen = 1'b0;
        strobe(4'h1);
        chk("window eof", tx_active_window, 1'b0);
        chk("no idle pulse", ri_seen, 1'b0);
        strobe(4'hc);
        chk("ack only", tx_active_window, 1'b0);
        wr(`VD_ADDR_CTRL, 8'h0c);
        strobe(4'h8);
        chk("window off", tx_active_window, 1'b0);
        $display("test transmit done");
    endtask : t_tx

    task automatic t_div;
        int k;
        int t1;
        do_reset;
        k = n_tick;
        mtick;
        chk("manual tick", 16'(n_tick - k), 16'h1);
        for (int c = 0; c < 2; c++) begin
            wr(`VD_ADDR_CTRL, 8'h00);
            wr(`VD_ADDR_CTRL, {4'(c), 4'h1});
            wait_tick;
            t1 = last_tick;
            wait_tick;
            chk("period", 16'(last_tick - t1), 16'((64 * SLOT) << c));
        end
        $display("test divider done");
    endtask : t_div

    task automatic t_pulsed;
        do_reset;
        wr(`VD_ADDR_STATUS, 8'h80);
        wr(`VD_ADDR_CTRL, 8'h08);
        stuck_a <= 1'b1;
        toggle(5);
        chk("pulsed rx", rx_data_out, 1'b0);
        chk("no diagnosis", code, 2'b00);
        lvl(1'b1, 1);
        rd(`VD_ADDR_STATUS);
        chk("pulsed status", rv, 8'h80);
        $display("test pulsed done");
    endtask : t_pulsed

    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        do_reset;
        t_reset;
        t_forced;
        t_auto(1'b1, ca);
        t_auto(1'b0, cb);
        chk("codes", {14'h0, ca ^ cb}, 16'h3);
        t_major;
        t_tx;
        t_div;
        t_pulsed;
        report_and_stop;
    end
endmodule : vandiag_top_tb
`default_nettype wire
